// ---- common/omfra_pkg.sv ----
// omfra_pkg: register map, field positions, reset values and carriers for the
// osd mesh/fade/row-attribute timing block.
// assumes a single 50 MHz clock; dot clock arrives as a one-cycle enable.
package omfra_pkg;

  // ------------------------------------------------------------------
  // register word indices (byte address is the index times four)
  // ------------------------------------------------------------------
  localparam logic [5:0] OMFRA_IDX_FADE_ROW  = 6'h05;
  localparam logic [5:0] OMFRA_IDX_FADE_LINE = 6'h06;
  localparam logic [5:0] OMFRA_IDX_MESH      = 6'h07;
  localparam logic [5:0] OMFRA_IDX_ROW_COLOUR_ATTRIBUTES  = 6'h08;
  localparam logic [5:0] OMFRA_IDX_TIMING    = 6'h09;
  localparam logic [5:0] OMFRA_IDX_ROW_SPACE = 6'h0a;
  localparam logic [5:0] OMFRA_IDX_IRQ_OPT   = 6'h0b;
  localparam logic [5:0] OMFRA_IDX_STATUS    = 6'h0c;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] OMFRA_RST_FADE_ROW  = 8'h00f0;
  localparam logic [7:0] OMFRA_RST_FADE_LINE = 8'h00e0;
  localparam logic [7:0] OMFRA_RST_MESH      = 8'h0000;
  localparam logic [7:0] OMFRA_RST_ROW_COLOUR_ATTRIBUTES  = 8'h0000;
  localparam logic [7:0] OMFRA_RST_TIMING    = 8'h0000;
  localparam logic [7:0] OMFRA_RST_ROW_SPACE = 8'h0000;
  localparam logic [7:0] OMFRA_RST_IRQ_OPT   = 8'h0080;
  localparam logic [7:0] OMFRA_FADE_ROW_ONES = 8'h00f0;
  localparam logic [7:0] OMFRA_FADE_LN_ONES  = 8'h00e0;
  localparam logic [7:0] OMFRA_IRQ_OPT_ONES  = 8'h0080;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int OMFRA_MC_HT_DLY   = 7;
  localparam int OMFRA_MC_COL_HI   = 6;
  localparam int OMFRA_MC_COL_LO   = 4;
  localparam int OMFRA_MC_PIN_HT   = 3;
  localparam int OMFRA_MC_FIELD    = 2;
  localparam int OMFRA_MC_SW_FIELD = 1;
  localparam int OMFRA_MC_EN       = 0;
  localparam int OMFRA_TM_BLK_HI   = 7;
  localparam int OMFRA_TM_BLK_LO   = 4;
  localparam int OMFRA_TM_FG_HT    = 3;
  localparam int OMFRA_TM_MESH_ROW = 0;
  localparam int OMFRA_RS_FADE_DIR = 6;
  localparam int OMFRA_RS_HT_HI    = 5;
  localparam int OMFRA_RS_HT_LO    = 4;
  localparam int OMFRA_IO_PENDING  = 6;
  localparam int OMFRA_RA_FG_OFF   = 7;
  localparam int OMFRA_RA_BG_ON    = 3;

  // ------------------------------------------------------------------
  // geometry and pixel map addressing
  // ------------------------------------------------------------------
  localparam logic [5:0] OMFRA_LINES_ROW   = 6'h12;   // 18 scan lines
  localparam logic [5:0] OMFRA_LINES_DBL   = 6'h24;   // 36 scan lines
  localparam logic [4:0] OMFRA_CELL_COLS   = 5'h0e;   // 14 pixels wide
  localparam logic [6:0] OMFRA_CHAR_STRIDE = 7'h40;   // gap after 0023h
  localparam int         OMFRA_CHAR_COUNT  = 512;
  localparam int         OMFRA_DLY_TAPS    = 16;

  // timing of the bus answer: one wait cycle on every access
  localparam int OMFRA_BUS_WAIT = 1;

  // pixel inputs from the character generator
  typedef struct packed {
    logic       active;      // inside the osd area
    logic       fg_bit;      // pixel map bit, 1 = foreground
    logic [8:0] colour_idx;  // 000h selects row attribute colour
    logic [2:0] char_rgb;    // colour from the character's own index
  } omfra_pix_t;

  // video outputs
  typedef struct packed {
    logic [2:0] rgb;
    logic       blank;
    logic       halftone;
  } omfra_vid_t;

endpackage

// ---- rtl/omfra_halfdly.sv ----
// omfra_halfdly: delays a level by a programmable number of half dot periods.
// assumes i_half is a one-cycle enable at twice the dot rate.
`timescale 1ns/100ps
module omfra_halfdly
  import omfra_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_half,
  input  wire logic [3:0] i_code,
  input  wire logic       i_sig,
  output logic            o_sig
);

  logic [OMFRA_DLY_TAPS-1:0] tap_reg;
  wire  [OMFRA_DLY_TAPS-1:0] tap_next = {tap_reg[OMFRA_DLY_TAPS-2:0], i_sig};
  wire                       sel_sig  = (i_code == 4'h0) ? i_sig : tap_reg[i_code - 4'h1];

  // -----------------------------------------------------------------
  // shift line: one tap per half dot period
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      tap_reg <= '0;
      o_sig   <= 1'b0;
    end
    else
    begin
      if (i_half)
        tap_reg <= tap_next;
      o_sig <= sel_sig;   // code zero still sees the one output flop
    end
  end

endmodule

// ---- rtl/omfra_rowtimer.sv ----
// omfra_rowtimer: counts scan lines into text rows from sync edges and
// derives the hardware field from the phase of vsync against hsync.
// assumes syncs are synchronous levels, active high, with vsync rising
// never on the same cycle as hsync.
`timescale 1ns/100ps
module omfra_rowtimer
  import omfra_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_hsync,
  input  wire logic       i_vsync,
  input  wire logic       i_double,
  output logic            o_row_start,
  output logic            o_field_start,
  output logic [3:0]      o_row,
  output logic [5:0]      o_line,
  output logic            o_odd_field
);

  logic       hs_d_reg;
  logic       vs_d_reg;
  logic [11:0] hpos_reg;      // clocks since the last hsync rise
  logic [11:0] hlen_reg;      // length of the last full line
  wire        hs_rise = i_hsync & ~hs_d_reg;
  wire        vs_rise = i_vsync & ~vs_d_reg;
  wire  [5:0] span    = i_double ? OMFRA_LINES_DBL : OMFRA_LINES_ROW;
  wire        row_end = (o_line == span - 6'h01);

  // -----------------------------------------------------------------
  // edge detection and line/row counting
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      hs_d_reg      <= 1'b0;
      vs_d_reg      <= 1'b0;
      hpos_reg      <= 12'h000;
      hlen_reg      <= 12'h000;
      o_row_start   <= 1'b0;
      o_field_start <= 1'b0;
      o_row         <= 4'h0;
      o_line        <= 6'h00;
      o_odd_field   <= 1'b0;
    end
    else
    begin
      hs_d_reg      <= i_hsync;
      vs_d_reg      <= i_vsync;
      o_field_start <= vs_rise;
      o_row_start   <= 1'b0;
      // line length is measured, so the field test needs no fixed timing
      hpos_reg      <= hs_rise ? 12'h000 : hpos_reg + 12'h001;
      if (hs_rise)
        hlen_reg <= hpos_reg;
      if (vs_rise)
      begin
        // vsync landing mid-line marks the odd field
        o_odd_field <= ({hpos_reg[10:0], 1'b0} >= hlen_reg);
        o_row       <= 4'h0;
        o_line      <= 6'h00;
      end
      else if (hs_rise)
      begin
        o_row_start  <= (o_line == 6'h00);
        if (row_end)
        begin
          o_line <= 6'h00;
          o_row  <= o_row + 4'h1;
        end
        else
          o_line <= o_line + 6'h01;
      end
    end
  end

endmodule

// ---- rtl/omfra_top.sv ----
// omfra_top: osd effects for a tv controller: blanking and halftone delay,
// mesh window, fade, row colour attributes, pixel map address and sync
// interrupts; registers over avalon-mm with waitrequest.
// assumes i_dot2_en pulses once per half dot period and sync inputs are
// synchronous to i_mclk.
//
// Function
// - blanking delayed by upper-nibble code
// - each code step adds half dot
// - bit 3 extends halftone to foreground
// - mesh row bit gates next row
// - mesh enable bit zero disables mesh
// - mesh colour bits six to four
// - bit 3 routes halftone to pin
// - bit 2: field and polarity select
// - bit 1: software or hardware field
// - halftone delayed in half dot steps
// - fade boundary row and direction
// - fade begins at programmed scan line
// - map bit one foreground, zero background
// - character maps spaced at 40h
// - 512 maps of 14x18 cells
// - index 000h uses row attribute colour
// - row foreground shown when bit 7 low
// - row background shown when bit 3 high
// - row and field interrupts on sync edges
// - rows 18 lines, doubled 36
// - option bit holds other interrupt pending
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
module omfra_top
  import omfra_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_dot2_en,
  input  wire logic        i_hsync,
  input  wire logic        i_vsync,
  input  wire logic        i_blank,
  input  wire logic        i_double_row,
  input  wire omfra_pix_t  i_pix,
  input  wire logic [8:0]  i_char_code,
  input  wire logic [4:0]  i_pix_col,
  input  wire logic        i_irq_done,
  output omfra_vid_t       o_vid,
  output logic             o_halftone_out_pin,
  output logic [15:0]      o_map_addr,
  output logic             o_row_irq,
  output logic             o_field_irq
);

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  logic [7:0] fade_boundary_row_reg;
  logic [7:0] fade_start_line_reg;
  logic [7:0] mesh_control_reg;
  logic [7:0] row_colour_attributes_reg;
  logic [7:0] osd_timing_reg;
  logic [7:0] row_space_reg;
  logic [7:0] irq_option_reg;
  logic       ack_reg;
  logic       row_mesh_reg;

  // -----------------------------------------------------------------
  // row timing
  // -----------------------------------------------------------------
  logic       row_start;
  logic       field_start;
  logic [3:0] cur_row;
  logic [5:0] cur_line;
  logic       hw_odd;

  omfra_rowtimer u_rowtimer
  (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_hsync       (i_hsync),
    .i_vsync       (i_vsync),
    .i_double      (i_double_row),
    .o_row_start   (row_start),
    .o_field_start (field_start),
    .o_row         (cur_row),
    .o_line        (cur_line),
    .o_odd_field   (hw_odd)
  );

  // -----------------------------------------------------------------
  // bus decode: one wait cycle, then the answer
  // -----------------------------------------------------------------
  wire       bus_req   = i_avs_read | i_avs_write;
  wire       bus_done  = bus_req & ack_reg;
  wire       wr_lane0  = i_avs_write & ack_reg & i_avs_byteenable[0];
  wire [5:0] word_idx  = {2'b00, i_avs_address[5:2]};
  wire       sel_frow  = (word_idx == OMFRA_IDX_FADE_ROW);
  wire       sel_fline = (word_idx == OMFRA_IDX_FADE_LINE);
  wire       sel_mesh  = (word_idx == OMFRA_IDX_MESH);
  wire       sel_attr  = (word_idx == OMFRA_IDX_ROW_COLOUR_ATTRIBUTES);
  wire       sel_tim   = (word_idx == OMFRA_IDX_TIMING);
  wire       sel_rsp   = (word_idx == OMFRA_IDX_ROW_SPACE);
  wire       sel_iopt  = (word_idx == OMFRA_IDX_IRQ_OPT);
  wire       sel_stat  = (word_idx == OMFRA_IDX_STATUS);
  wire [7:0] wbyte     = i_avs_writedata[7:0];

  assign o_avs_waitrequest = bus_req & ~ack_reg;

  // read mux; unmapped words read zero, reserved high bits read one
  wire [7:0] rd_byte =
      sel_frow  ? (fade_boundary_row_reg | OMFRA_FADE_ROW_ONES) :
      sel_fline ? (fade_start_line_reg | OMFRA_FADE_LN_ONES) :
      sel_mesh  ? mesh_control_reg :
      sel_attr  ? row_colour_attributes_reg :
      sel_tim   ? osd_timing_reg :
      sel_rsp   ? row_space_reg :
      sel_iopt  ? (irq_option_reg | OMFRA_IRQ_OPT_ONES) :
      sel_stat  ? {o_row_irq, o_field_irq, hw_odd, 1'b0, cur_row} :
      8'h00;

  // -----------------------------------------------------------------
  // bus handshake and register writes
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      ack_reg                   <= 1'b0;
      o_avs_readdata            <= 32'h0000_0000;
      fade_boundary_row_reg     <= OMFRA_RST_FADE_ROW;
      fade_start_line_reg       <= OMFRA_RST_FADE_LINE;
      mesh_control_reg          <= OMFRA_RST_MESH;
      row_colour_attributes_reg <= OMFRA_RST_ROW_COLOUR_ATTRIBUTES;
      osd_timing_reg            <= OMFRA_RST_TIMING;
      row_space_reg             <= OMFRA_RST_ROW_SPACE;
      irq_option_reg            <= OMFRA_RST_IRQ_OPT;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (i_avs_read & ~ack_reg)
        o_avs_readdata <= {24'h00_0000, rd_byte};
      if (wr_lane0 & sel_frow)
        fade_boundary_row_reg <= wbyte | OMFRA_FADE_ROW_ONES;
      if (wr_lane0 & sel_fline)
        fade_start_line_reg <= wbyte | OMFRA_FADE_LN_ONES;
      if (wr_lane0 & sel_mesh)
        mesh_control_reg <= wbyte;
      if (wr_lane0 & sel_attr)
        row_colour_attributes_reg <= wbyte;
      if (wr_lane0 & sel_tim)
        osd_timing_reg <= wbyte;
      if (wr_lane0 & sel_rsp)
        row_space_reg <= wbyte;
      if (wr_lane0 & sel_iopt)
        irq_option_reg <= wbyte | OMFRA_IRQ_OPT_ONES;
    end
  end

  // -----------------------------------------------------------------
  // interrupts: a second event waits while one is served if enabled
  // -----------------------------------------------------------------
  logic row_pend_reg;
  logic fld_pend_reg;
  wire  pend_en  = irq_option_reg[OMFRA_IO_PENDING];
  wire  busy     = o_row_irq | o_field_irq;
  wire  row_take = (row_start | row_pend_reg) & ~busy & ~field_start;
  wire  fld_take = (field_start | fld_pend_reg) & ~busy;

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_row_irq    <= 1'b0;
      o_field_irq  <= 1'b0;
      row_pend_reg <= 1'b0;
      fld_pend_reg <= 1'b0;
    end
    else
    begin
      // the clear from software wins; an event in that cycle is held off by busy and kept only if pending is on
      o_row_irq   <= row_take | (o_row_irq & ~i_irq_done);
      o_field_irq <= fld_take | (o_field_irq & ~i_irq_done);
      row_pend_reg <= pend_en & ~row_take &
                      (row_pend_reg | (row_start & (busy | field_start)));
      fld_pend_reg <= pend_en & ~fld_take & (fld_pend_reg | (field_start & busy));
    end
  end

  // -----------------------------------------------------------------
  // mesh window: row bit sampled at each row start
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      row_mesh_reg <= 1'b0;
    else if (row_start)
      row_mesh_reg <= osd_timing_reg[OMFRA_TM_MESH_ROW];
  end

  wire       mesh_on   = mesh_control_reg[OMFRA_MC_EN] & row_mesh_reg;
  wire       sw_field  = mesh_control_reg[OMFRA_MC_FIELD];
  wire       field_sel = mesh_control_reg[OMFRA_MC_SW_FIELD] ? sw_field : hw_odd;
  // mesh on lines of the selected field parity
  wire       mesh_line = mesh_on & (cur_line[0] == field_sel);
  wire [2:0] mesh_bgr  = mesh_control_reg[OMFRA_MC_COL_HI:OMFRA_MC_COL_LO];
  wire [2:0] mesh_rgb  = {mesh_bgr[0], mesh_bgr[1], mesh_bgr[2]};
  wire       pin_mode  = mesh_control_reg[OMFRA_MC_PIN_HT];

  // -----------------------------------------------------------------
  // fade: rows past the boundary line vanish in the chosen direction
  // -----------------------------------------------------------------
  wire [3:0] f_row   = fade_boundary_row_reg[3:0];
  wire [4:0] f_line  = fade_start_line_reg[4:0];
  wire       below   = (cur_row > f_row) ||
                       ((cur_row == f_row) && (cur_line >= {1'b0, f_line}));
  wire       faded   = row_space_reg[OMFRA_RS_FADE_DIR] ? ~below : below;

  // -----------------------------------------------------------------
  // pixel colour
  // -----------------------------------------------------------------
  wire       use_row = (i_pix.colour_idx == 9'h000);
  wire       fg_ok   = ~row_colour_attributes_reg[OMFRA_RA_FG_OFF];
  wire       bg_ok   = row_colour_attributes_reg[OMFRA_RA_BG_ON];
  wire [2:0] fg_rgb  = use_row ? (fg_ok ? row_colour_attributes_reg[6:4] : 3'h0)
                               : i_pix.char_rgb;
  wire [2:0] bg_rgb  = use_row & bg_ok ? row_colour_attributes_reg[2:0] : 3'h0;
  wire [2:0] base    = i_pix.fg_bit ? fg_rgb : bg_rgb;
  wire       ht_pix  = ~i_pix.fg_bit | osd_timing_reg[OMFRA_TM_FG_HT];
  wire       mesh_px = i_pix.active & mesh_line & ht_pix & ~faded;
  wire [2:0] rgb_nx  = (~i_pix.active | faded) ? 3'h0 :
                       (mesh_px & ~pin_mode) ? mesh_rgb : base;
  // negative polarity in pin mode follows bit 2
  wire       ht_raw  = pin_mode & (mesh_px ^ sw_field);

  // -----------------------------------------------------------------
  // output delays in half dot steps
  // -----------------------------------------------------------------
  wire [3:0] blk_code = osd_timing_reg[OMFRA_TM_BLK_HI:OMFRA_TM_BLK_LO];
  wire [3:0] ht_code  = {1'b0, row_space_reg[OMFRA_RS_HT_HI:OMFRA_RS_HT_LO],
                         mesh_control_reg[OMFRA_MC_HT_DLY]};
  logic blank_dly;
  logic ht_dly;

  omfra_halfdly u_blank_dly
  (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_half   (i_dot2_en),
    .i_code   (blk_code),
    .i_sig    (i_blank),
    .o_sig    (blank_dly)
  );

  omfra_halfdly u_ht_dly
  (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_half   (i_dot2_en),
    .i_code   (ht_code),
    .i_sig    (ht_raw),
    .o_sig    (ht_dly)
  );

  // -----------------------------------------------------------------
  // pixel map address: 40h per character, 14 columns of a line
  // -----------------------------------------------------------------
  wire [15:0] map_nx = {1'b0, i_char_code, 6'h00} +
                       {10'h000, (i_pix_col < OMFRA_CELL_COLS) ? i_pix_col[4:3] : 2'h0,
                        4'h0} +
                       {11'h000, cur_line[4:0]};

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_vid              <= '0;
      o_halftone_out_pin <= 1'b0;
      o_map_addr         <= 16'h0000;
    end
    else
    begin
      o_vid.rgb          <= rgb_nx;
      o_vid.blank        <= blank_dly;
      o_vid.halftone     <= ht_dly;
      o_halftone_out_pin <= ht_dly;
      o_map_addr         <= map_nx;
    end
  end

endmodule

// ---- verification/omfra_sync_model.sv ----
// omfra_sync_model: tv sync source with active-high hsync and vsync.
// assumes the bench raises i_run only after the block leaves reset.
`timescale 1ns/100ps
module omfra_sync_model
  import omfra_pkg::*;
#(
  parameter int H_CYC   = 40,  // line period in clocks
  parameter int H_W     = 4,   // hsync width
  parameter int V_LINES = 120, // lines per field
  parameter int V_OFS   = 20,  // vsync rise lands mid-line
  parameter int V_W     = 100  // wider than 1.5 x (40 + 4)
) (
  input  wire logic i_mclk,
  input  wire logic i_run,
  output logic      o_hsync = 1'b0,
  output logic      o_vsync = 1'b0
);
  int hcnt_reg = 0;
  int pos_reg  = 0;
  // counters park at zero while stopped, so both syncs stand low between runs
  always @(posedge i_mclk)
  begin
    hcnt_reg <= (!i_run || hcnt_reg == H_CYC - 1) ? 0 : hcnt_reg + 1;
    pos_reg  <= (!i_run || pos_reg == H_CYC * V_LINES - 1) ? 0 : pos_reg + 1;
    o_hsync  <= i_run && hcnt_reg < H_W;
    o_vsync  <= i_run && pos_reg >= V_OFS && pos_reg < V_OFS + V_W;
  end
endmodule

// ---- verification/omfra_top_sva.sv ----
// omfra_top_sva: bus handshake and sync interrupt checks on omfra_top ports.
// assumes the interrupt option bit stays clear, so nothing is held pending.
`timescale 1ns/100ps
module omfra_top_sva
  import omfra_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_hsync,
  input wire logic        i_vsync,
  input wire logic        i_irq_done,
  input wire logic        o_row_irq,
  input wire logic        o_field_irq
);
  logic [2:0] quiet_reg;
  wire        req = i_avs_read || i_avs_write;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  // cycles since a sync rise; a clear is judged only once events have landed
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn || $rose(i_hsync) || $rose(i_vsync))
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  a_req_wait: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("fresh request not held off one cycle");
  a_bus_ack: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_idle_wait: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest without a request");
  a_rd_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_field_irq: assert property ($rose(i_vsync) && !o_row_irq && !o_field_irq |-> ##[1:3] o_field_irq)
    else $error("vsync rise raised no field interrupt");
  a_field_src: assert property ($rose(o_field_irq) |-> $past(i_vsync, 2) && !$past(i_vsync, 3))
    else $error("field interrupt without a vsync rise");
  a_row_src: assert property ($rose(o_row_irq) |-> $past(i_hsync, 2) && !$past(i_hsync, 3))
    else $error("row interrupt without an hsync rise");
  a_irq_clear: assert property (i_irq_done && quiet_reg >= 3'h3 |=> !o_row_irq && !o_field_irq)
    else $error("interrupt survived its clear");
endmodule
bind omfra_top omfra_top_sva omfra_top_sva_i (.i_mclk, .i_resetn, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .i_hsync, .i_vsync, .i_irq_done, .o_row_irq, .o_field_irq);

// ---- verification/testbench.sv ----
// testbench: registers, blanking delay, row colours and row interrupts of omfra_top.
// assumes omfra_sync_model drives the syncs; one 50 MHz clock for all.
`timescale 1ns/100ps
module testbench
  import omfra_pkg::*;
;
  logic        i_mclk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [5:0]  i_avs_address = 6'h00;
  logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, v;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic        i_dot2_en = 1'b1, i_blank = 1'b0, i_double_row = 1'b0, i_irq_done = 1'b0;
  logic        run = 1'b0, smp = 1'b0, o_avs_waitrequest, i_hsync, i_vsync;
  logic        o_halftone_out_pin, o_row_irq, o_field_irq;
  omfra_pix_t  i_pix = '0;
  omfra_vid_t  o_vid;
  logic [8:0]  i_char_code = 9'h000;
  logic [4:0]  i_pix_col = 5'h00;
  logic [15:0] o_map_addr;
  logic [7:0]  a, exp_rd[$], exp_rgb[$];
  int          exp_dly[$], exp_ln[$], dly, nl, svc, cyc, n_errors = 0, checks = 0, seed = 23309;
  logic        blk_q, vb_q, hs_q, vs_q, ri_q, have_row = 1'b0;
  always #10 i_mclk = ~i_mclk;
  omfra_top omfra_top_i (.i_mclk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_dot2_en,
    .i_hsync, .i_vsync, .i_blank, .i_double_row, .i_pix, .i_char_code, .i_pix_col,
    .i_irq_done, .o_vid, .o_halftone_out_pin, .o_map_addr, .o_row_irq, .o_field_irq);
  omfra_sync_model omfra_sync_model_i (.i_mclk, .i_run(run), .o_hsync(i_hsync), .o_vsync(i_vsync));
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk_val(8'(got), 8'(exp));
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one bus cycle: held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
    i_avs_address    <= {idx[3:0], 2'b00};
    i_avs_write      <= w;
    i_avs_read       <= !w;
    i_avs_writedata  <= {24'h00_0000, d};
    i_avs_byteenable <= be;
    @(posedge i_mclk);
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_mclk);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask
  // watcher: each answer takes the oldest note off its queue
  always @(posedge i_mclk)
  begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && exp_rd.size() > 0)
      chk_val(o_avs_readdata[7:0], exp_rd.pop_front());
    if (smp && exp_rgb.size() > 0)
      chk_val({5'h00, o_vid.rgb}, exp_rgb.pop_front());
    dly = (i_blank && !blk_q) ? 0 : dly + 1;
    if (o_vid.blank && !vb_q && exp_dly.size() > 0)
      chk_cnt(dly, exp_dly.pop_front());
    if (i_vsync && !vs_q)
      have_row = 1'b0;
    if (i_hsync && !hs_q)
      nl++;
    if (o_row_irq && !ri_q)
    begin
      if (have_row && exp_ln.size() > 0)
        chk_cnt(nl, exp_ln.pop_front());
      have_row = 1'b1;
      nl = 0;
    end
    {blk_q, vb_q, hs_q, vs_q, ri_q} = {i_blank, o_vid.blank, i_hsync, i_vsync, o_row_irq};
  end
  // interrupt service: the flag stands a few cycles before it is cleared
  always @(posedge i_mclk)
  begin
    svc = (o_row_irq || o_field_irq) ? svc + 1 : 0;
    i_irq_done <= (svc == 6);
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    rd(OMFRA_IDX_FADE_ROW, 8'hf0);
    rd(OMFRA_IDX_FADE_LINE, 8'he0);
    rd(OMFRA_IDX_MESH, 8'h00);
    rd(OMFRA_IDX_IRQ_OPT, 8'h80);
    wr(OMFRA_IDX_FADE_ROW, 8'h0a);
    rd(OMFRA_IDX_FADE_ROW, 8'hfa);
    wr(OMFRA_IDX_FADE_LINE, 8'h13);
    rd(OMFRA_IDX_FADE_LINE, 8'hf3);
    v = $random(seed);
    wr(OMFRA_IDX_MESH, v[7:0]);
    bus(1'b1, OMFRA_IDX_MESH, ~v[7:0], 4'he);
    rd(OMFRA_IDX_MESH, v[7:0]);
    wr(6'h0f, 8'h55);
    rd(6'h0f, 8'h00);
    // mesh off and the fade boundary past the last line, so colours pass untouched
    wr(OMFRA_IDX_MESH, 8'h00);
    wr(OMFRA_IDX_FADE_ROW, 8'h0f);
    wr(OMFRA_IDX_FADE_LINE, 8'h1f);
    // every blanking code; the dot enable pulses each cycle, so one step is one clock
    for (int k = 0; k < 16; k++)
    begin
      wr(OMFRA_IDX_TIMING, {k[3:0], 4'h0});
      exp_dly.push_back(k + 2);
      i_blank <= 1'b1;
      repeat (24) @(posedge i_mclk);
      i_blank <= 1'b0;
      repeat (24) @(posedge i_mclk);
    end
    // attribute colours for all enable and pixel combinations
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      a = {i[0], v[6:4], i[1], v[2:0]};
      wr(OMFRA_IDX_ROW_COLOUR_ATTRIBUTES, a);
      i_pix <= '{active: 1'b1, fg_bit: i[2], colour_idx: 9'h000, char_rgb: v[10:8]};
      i_char_code <= v[20:12];
      repeat (20) @(posedge i_mclk);
      exp_rgb.push_back(i[2] ? (a[7] ? 8'h00 : {5'h00, a[6:4]}) : (a[3] ? {5'h00, a[2:0]} : 8'h00));
      chk_val(o_map_addr[15:8], {1'b0, v[20:14]});
      chk_val(o_map_addr[7:0], {v[13:12], 6'h00});
      chk_val({7'h00, o_halftone_out_pin}, 8'h00);
      smp <= 1'b1;
      @(posedge i_mclk);
      smp <= 1'b0;
    end
    // syncs on: row heights of 18, then 36 once a new field begins
    i_pix <= '0;
    run <= 1'b1;
    repeat (3) exp_ln.push_back(18);
    while (exp_ln.size() > 0)
      @(posedge i_mclk);
    i_double_row <= 1'b1;
    @(posedge i_vsync);
    repeat (3) exp_ln.push_back(36);
    while (exp_ln.size() > 0)
      @(posedge i_mclk);
    chk_cnt(exp_rd.size() + exp_rgb.size() + exp_dly.size(), 0);
    final_report();
  end
endmodule
